// [lsss_pkg.sv]
// package: register map, field positions and reset values of the sync status block
package lsss_pkg;
   // register byte addresses on the wishbone slave
   localparam logic [7:0] LSSS_ADDR_STATUS = 8'h00;
   localparam logic [7:0] LSSS_ADDR_ERR_LOW = 8'h04;
   localparam logic [7:0] LSSS_ADDR_CTRL = 8'h08;
   localparam logic [7:0] LSSS_ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] LSSS_ADDR_IRQ_MASK = 8'h10;
   localparam int LSSS_ADDR_W = 8;

   // sync status register field positions
   localparam int LSSS_BIT_BUSY = 7;
   localparam int LSSS_BIT_LOCKED = 3;
   localparam int LSSS_BIT_ROTATED = 2;
   localparam int LSSS_BIT_WLIM = 1;
   localparam int LSSS_BIT_TRIPPED = 0;

   // control register fields
   localparam int LSSS_BIT_ARM = 0;
   localparam int LSSS_THR_LSB = 8;
   localparam int LSSS_THR_MSB = 15;

   // interrupt status / mask layout
   localparam int LSSS_IRQ_TRIP = 0;
   localparam int LSSS_IRQ_LOCK = 1;
   localparam int LSSS_IRQ_WLIM = 2;
   localparam int LSSS_IRQ_DONE = 3;
   localparam int LSSS_IRQ_W = 4;

   // reset values
   localparam logic [7:0] LSSS_RST_STATUS = 8'h00;
   localparam logic [7:0] LSSS_RST_ERR = 8'h00;
   localparam logic [7:0] LSSS_RST_THR = 8'h00;
   localparam logic [3:0] LSSS_RST_IRQ = 4'h0;
   localparam logic [7:0] LSSS_CNT_ZERO = 8'h00;
   localparam logic [7:0] LSSS_CNT_ONE = 8'h01;

   // default multiframe length in dac clock cycles
   localparam int LSSS_LMFC_PERIOD = 32;

   // sync machine states
   typedef enum logic [1:0] {
      LSSS_IDLE = 2'b00,
      LSSS_ARMED = 2'b01,
      LSSS_SETTLE = 2'b10
   } lsss_state_t;
endpackage : lsss_pkg

// [lsss_sync_status.sv]
// module: lmfc to sysref alignment machine with status, phase error and wishbone registers
//
// Summary of operation
// - busy reads high while sync machine runs
// - locked bit 3 set when aligned within window
// - rotated bit 2 sticky when lmfc shifted
// - window bit 1 set when error outside threshold
// - tripped bit 0 sticky on sysref after arming
// - 9-bit signed error, low byte readable
// - error counts dac clocks lmfc to sysref
// - status and error reset zero, writes ignored
`timescale 1ns/1ps
module lsss_sync_status import lsss_pkg::*; #(
   parameter int LMFC_PERIOD = LSSS_LMFC_PERIOD
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [LSSS_ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic sysref_i,
   output logic lmfc_o,
   output logic irq_o
);
   // counter holds at most 256 states and the signed error must fit 9 bits
   if (LMFC_PERIOD < 2 || LMFC_PERIOD > 256) begin : g_bad_period
      $error("LMFC_PERIOD must lie in 2..256");
   end

   // counter end points and the period used to fold the error negative
   localparam logic [7:0] CNT_LAST = 8'(LMFC_PERIOD - 1);
   localparam logic [7:0] CNT_HALF = 8'(LMFC_PERIOD / 2);
   localparam logic [8:0] PERIOD_W = 9'(LMFC_PERIOD);

   lsss_state_t state, next_state;
   logic [7:0] lmfc_cnt, next_lmfc_cnt;
   logic locked, next_locked;
   logic rotated, next_rotated;
   logic wlim, next_wlim;
   logic tripped, next_tripped;
   logic [8:0] phase_err, next_phase_err;
   logic [7:0] thr, next_thr;
   logic [3:0] irq_stat, next_irq_stat;
   logic [3:0] irq_mask, next_irq_mask;
   logic ack, next_ack;
   logic [31:0] rdata, next_rdata;

   logic busy;
   logic wr_go;
   logic arm_req;
   logic capture;
   logic [8:0] meas_err;
   logic [8:0] abs_err;
   logic outside;
   logic [3:0] irq_evt;
   logic [7:0] status_word;

   // bus qualifiers: a write lands on the edge where ack is high
   assign wr_go = cyc_i & stb_i & we_i & ack;
   assign arm_req = wr_go && adr_i == LSSS_ADDR_CTRL && sel_i[0] && dat_i[LSSS_BIT_ARM];
   assign busy = state != LSSS_IDLE;
   assign capture = state == LSSS_ARMED && sysref_i;

   // signed distance from last lmfc edge; late half wraps negative
   always_comb begin
      if (lmfc_cnt < CNT_HALF) begin
         meas_err = {1'b0, lmfc_cnt};
      end else begin
         meas_err = 9'({1'b0, lmfc_cnt} - PERIOD_W);
      end
      abs_err = meas_err[8] ? 9'(-meas_err) : meas_err;
      outside = abs_err > {1'b0, thr};
   end

   // status byte built from the named field positions; reserved bits read zero
   always_comb begin
      status_word = LSSS_RST_STATUS;
      status_word[LSSS_BIT_BUSY] = busy;
      status_word[LSSS_BIT_LOCKED] = locked;
      status_word[LSSS_BIT_ROTATED] = rotated;
      status_word[LSSS_BIT_WLIM] = wlim;
      status_word[LSSS_BIT_TRIPPED] = tripped;
   end

   // lmfc edge marker, high for the one cycle the counter is zero
   assign lmfc_o = lmfc_cnt == LSSS_CNT_ZERO;

   // sync machine, lmfc counter and result flags
   always_comb begin
      next_state = state;
      next_locked = locked;
      next_rotated = rotated;
      next_wlim = wlim;
      next_tripped = tripped;
      next_phase_err = phase_err;
      next_lmfc_cnt = (lmfc_cnt == CNT_LAST) ? LSSS_CNT_ZERO : 8'(lmfc_cnt + LSSS_CNT_ONE);
      case (state)
         LSSS_IDLE: begin
            if (arm_req) begin
               next_state = LSSS_ARMED;
               next_rotated = 1'b0;
               next_tripped = 1'b0;
               next_locked = 1'b0;
               next_wlim = 1'b0;
            end
         end
         LSSS_ARMED: begin
            if (sysref_i) begin
               next_tripped = 1'b1;
               next_phase_err = meas_err;
               next_wlim = outside;
               next_locked = !outside;
               if (meas_err != 9'h000) begin
                  // this sysref cycle becomes the lmfc edge
                  next_lmfc_cnt = LSSS_CNT_ONE;
                  next_rotated = 1'b1;
               end
               next_state = LSSS_SETTLE;
            end
         end
         LSSS_SETTLE: begin
            next_state = LSSS_IDLE;
         end
         default: begin
            next_state = LSSS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= LSSS_IDLE;
         lmfc_cnt <= LSSS_CNT_ZERO;
         locked <= 1'b0;
         rotated <= 1'b0;
         wlim <= 1'b0;
         tripped <= 1'b0;
         phase_err <= {1'b0, LSSS_RST_ERR};
      end else begin
         state <= next_state;
         lmfc_cnt <= next_lmfc_cnt;
         locked <= next_locked;
         rotated <= next_rotated;
         wlim <= next_wlim;
         tripped <= next_tripped;
         phase_err <= next_phase_err;
      end
   end

   // interrupt events: set wins over a same-cycle write-one-to-clear
   always_comb begin
      irq_evt = '0;
      irq_evt[LSSS_IRQ_TRIP] = capture;
      irq_evt[LSSS_IRQ_LOCK] = capture && !outside;
      irq_evt[LSSS_IRQ_WLIM] = capture && outside;
      irq_evt[LSSS_IRQ_DONE] = state == LSSS_SETTLE;
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      next_thr = thr;
      if (wr_go && sel_i[0]) begin
         if (adr_i == LSSS_ADDR_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~dat_i[LSSS_IRQ_W-1:0];
         end
         if (adr_i == LSSS_ADDR_IRQ_MASK) begin
            next_irq_mask = dat_i[LSSS_IRQ_W-1:0];
         end
      end
      if (wr_go && sel_i[1] && adr_i == LSSS_ADDR_CTRL) begin
         next_thr = dat_i[LSSS_THR_MSB:LSSS_THR_LSB];
      end
      next_irq_stat = next_irq_stat | irq_evt;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= LSSS_RST_IRQ;
         irq_mask <= LSSS_RST_IRQ;
         thr <= LSSS_RST_THR;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         thr <= next_thr;
      end
   end

   // level interrupt from unmasked sticky events
   assign irq_o = |(irq_stat & irq_mask);

   // wishbone slave: ack one cycle after request, unmapped reads as zero
   always_comb begin
      next_ack = cyc_i & stb_i & ~ack;
      next_rdata = 32'h0000_0000;
      case (adr_i)
         LSSS_ADDR_STATUS: next_rdata[7:0] = status_word;
         LSSS_ADDR_ERR_LOW: next_rdata[7:0] = phase_err[7:0];
         LSSS_ADDR_CTRL: next_rdata[LSSS_THR_MSB:LSSS_THR_LSB] = thr;
         LSSS_ADDR_IRQ_STAT: next_rdata[LSSS_IRQ_W-1:0] = irq_stat;
         LSSS_ADDR_IRQ_MASK: next_rdata[LSSS_IRQ_W-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ack <= next_ack;
         rdata <= next_rdata;
      end
   end

   // bus outputs straight from their flip-flops
   assign ack_o = ack;
   assign dat_o = rdata;

   // checks on the sync machine and its reported results
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // arming write accepted by an idle machine
   sequence s_arm;
      state == LSSS_IDLE && arm_req;
   endsequence

   // first sysref seen while armed
   sequence s_capture;
      state == LSSS_ARMED && sysref_i;
   endsequence

   // armed machine still waiting for its reference
   sequence s_wait;
      state == LSSS_ARMED && !sysref_i;
   endsequence

   // idle machine with no arming write and nothing tripped
   sequence s_quiet;
      state == LSSS_IDLE && !arm_req && !tripped;
   endsequence

   // busy covers the whole attempt and nothing more
   a_busy_on_arm: assert property (s_arm |=> busy ##1 busy)
      else $error("busy not held after arming");

   a_busy_waits: assert property (s_wait |=> busy && state == LSSS_ARMED)
      else $error("machine left armed state without sysref");

   a_busy_clears: assert property (s_capture |=> busy ##1 !busy)
      else $error("busy did not clear two cycles after capture");

   // result flags of one capture
   a_lock_flag: assert property (s_capture and (!outside) |=> locked && !wlim)
      else $error("locked flag wrong after in-window capture");

   a_rotate_flag: assert property (s_capture and (meas_err != 9'h000)
      |=> rotated && lmfc_cnt == LSSS_CNT_ONE)
      else $error("rotation not reported or not applied");

   a_rotate_sticky: assert property (rotated && !arm_req |=> rotated)
      else $error("rotated flag dropped without rearm");

   a_window_flag: assert property (s_capture and outside |=> wlim && !locked)
      else $error("window flag wrong after out-of-window capture");

   a_trip_flag: assert property (s_capture |=> tripped)
      else $error("tripped flag not set by sysref");

   a_trip_sticky: assert property (tripped && !arm_req |=> tripped)
      else $error("tripped flag dropped without rearm");

   a_idle_no_trip: assert property (s_quiet |=> !tripped)
      else $error("sysref tripped an idle machine");

   // phase error capture, sign and hold
   a_err_low: assert property (s_capture |=> phase_err == $past(meas_err))
      else $error("phase error not captured");

   a_err_sign: assert property (s_capture |=> phase_err[8] == ($past(lmfc_cnt) >= CNT_HALF))
      else $error("phase error sign wrong");

   a_err_hold: assert property (!capture |=> $stable(phase_err))
      else $error("phase error changed without capture");

   a_err_zero_edge: assert property (s_capture and lmfc_o |=> phase_err == 9'h000 && !rotated)
      else $error("error nonzero for sysref on lmfc edge");

   a_lmfc_wrap: assert property (lmfc_cnt == CNT_LAST && !capture |=> lmfc_o)
      else $error("lmfc counter did not wrap at the period end");

   // reset values and read-only behaviour
   a_status_reset: assert property (disable iff (1'b0) rst_i |=> status_word == LSSS_RST_STATUS
      && phase_err[7:0] == LSSS_RST_ERR)
      else $error("status or error not zero after reset");

   a_status_ro: assert property (wr_go && adr_i == LSSS_ADDR_STATUS && state == LSSS_IDLE
      |=> $stable(status_word))
      else $error("write changed a read-only status bit");

   a_arm_clears: assert property (s_arm |=> !rotated && !tripped)
      else $error("sticky flags survived rearm");
endmodule : lsss_sync_status

// [lsss_sysref_src.sv]
// sysref source model that lands one pulse at a chosen lmfc phase
`timescale 1ns/1ps
module lsss_sysref_src #(
   parameter int LMFC_PERIOD = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lmfc_i,
   input wire logic go_i,
   input wire logic [7:0] off_i,
   output logic sysref_o
);
   // own wrap point, so a pulse can also land on phase zero
   localparam logic [7:0] LAST = 8'(LMFC_PERIOD - 1);
   logic [7:0] pos;
   logic [7:0] nxt;
   logic pend;
   logic seen;
   logic fire;
   // own copy of the lmfc phase; waits for a fresh lmfc edge since a rotation moves it
   assign nxt = lmfc_i ? 8'h01 : ((pos == LAST) ? 8'h00 : 8'(pos + 8'h01));
   assign fire = pend && (seen || lmfc_i) && nxt == off_i;
   // one-cycle pulse, line low whenever no pulse is due
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos <= 8'h00;
         pend <= 1'b0;
         seen <= 1'b0;
         sysref_o <= 1'b0;
      end else begin
         pos <= nxt;
         sysref_o <= fire;
         pend <= go_i | (pend & ~fire);
         seen <= ~go_i & (seen | lmfc_i);
      end
   end
endmodule : lsss_sysref_src

// [tb_lsss_sync_status.sv]
// testbench for the sync status block: registers, captures and interrupt
`timescale 1ns/1ps
module tb_lsss_sync_status import lsss_pkg::*;;
   localparam int P = 8;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic ack, lmfc, irq, sysref;
   logic [7:0] adr = 8'h00, off = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat, q;
   int n_fail = 0, n_compared = 0;
   // 50 MHz clock
   always #10 clk_i = ~clk_i;
   lsss_sync_status #(.LMFC_PERIOD(P)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .sysref_i(sysref), .lmfc_o(lmfc), .irq_o(irq));
   lsss_sysref_src #(.LMFC_PERIOD(P)) src (.clk_i(clk_i), .rst_i(rst_i), .lmfc_i(lmfc), .go_i(go), .off_i(off),
      .sysref_o(sysref));
   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one classic cycle, held until ack is sampled; read data lands in q
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (i >= 50) begin
         n_fail++;
         print_verdict();
      end
   endtask : wb
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask : rd_chk
   task fire(input logic [7:0] o);
      @(posedge clk_i);
      go <= 1'b1;
      off <= o;
      @(posedge clk_i);
      go <= 1'b0;
   endtask : fire
   // reset values, writes to read-only places, a sysref while idle
   task check_reset;
      wb(1'b1, LSSS_ADDR_STATUS, 32'hFF);
      wb(1'b1, LSSS_ADDR_ERR_LOW, 32'hFF);
      fire(8'h03);
      repeat (12) @(posedge clk_i);
      rd_chk(LSSS_ADDR_STATUS, 32'h0);
      rd_chk(LSSS_ADDR_ERR_LOW, 32'h0);
      rd_chk(8'h40, 32'h0);
      rd_chk(LSSS_ADDR_IRQ_STAT, 32'h0);
   endtask : check_reset
   // arm, land sysref at phase o, check flags and the signed error
   task sync_run(input logic [7:0] thr, input int o);
      int e;
      int k;
      logic [7:0] st;
      e = (o % P < P / 2) ? o % P : o % P - P;
      st = 8'h00;
      st[LSSS_BIT_TRIPPED] = 1'b1;
      st[LSSS_BIT_ROTATED] = (e != 0);
      st[LSSS_BIT_LOCKED] = (e <= int'(thr) && -e <= int'(thr));
      st[LSSS_BIT_WLIM] = !st[LSSS_BIT_LOCKED];
      wb(1'b1, LSSS_ADDR_CTRL, {16'h0, thr, 8'h01});
      rd_chk(LSSS_ADDR_STATUS, 32'h80);
      fire(8'(o % P));
      k = 0;
      while (q[LSSS_BIT_BUSY] !== 1'b0 && k < 20) begin
         wb(1'b0, LSSS_ADDR_STATUS, 32'h0);
         k++;
      end
      if (q[LSSS_BIT_BUSY] !== 1'b0) begin
         n_fail++;
         print_verdict();
      end
      chk(q, {24'h0, st});
      rd_chk(LSSS_ADDR_ERR_LOW, {24'h0, e[7:0]});
      rd_chk(LSSS_ADDR_CTRL, {16'h0, thr, 8'h00});
      wb(1'b1, LSSS_ADDR_STATUS, 32'h0);
      rd_chk(LSSS_ADDR_STATUS, {24'h0, st});
   endtask : sync_run
   // events pile up masked, then one is unmasked and cleared
   task check_irq;
      rd_chk(LSSS_ADDR_IRQ_STAT, 32'hF);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, LSSS_ADDR_IRQ_MASK, 32'h1);
      @(posedge clk_i);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, LSSS_ADDR_IRQ_STAT, 32'h1);
      @(posedge clk_i);
      chk({31'h0, irq}, 32'h0);
      rd_chk(LSSS_ADDR_IRQ_STAT, 32'hE);
   endtask : check_irq
   // lmfc marker: one cycle high, once per multiframe
   task check_lmfc;
      int k;
      int gap;
      k = 0;
      gap = 0;
      while (lmfc !== 1'b1 && k < 2 * P) begin
         @(posedge clk_i);
         k++;
      end
      do begin
         @(posedge clk_i);
         gap++;
      end while (lmfc !== 1'b1 && gap < 2 * P);
      if (k >= 2 * P || gap >= 2 * P) begin
         n_fail++;
         print_verdict();
      end
      chk(gap, P);
   endtask : check_lmfc
   // main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      check_reset();
      check_lmfc();
      sync_run(8'h02, 3);
      sync_run(8'h02, 6);
      sync_run(8'h02, 8);
      check_lmfc();
      check_irq();
      print_verdict();
   end
endmodule : tb_lsss_sync_status
